/* rtl/ssh_standby_map.svh */
// offsets, field positions, reset values and wait counts of the standby controller
// assumes inclusion by bare name; definitions only
`ifndef SSH_STANDBY_MAP_SVH
`define SSH_STANDBY_MAP_SVH

// ==========================================================================
// register indices on the plain register port
`define SSH_ADDR_PCC 2'h0
`define SSH_ADDR_CFG 2'h1
`define SSH_ADDR_TEST 2'h2
`define SSH_ADDR_STAT 2'h3

// ==========================================================================
// processor clock control fields, register reset values and the test enable field
`define SSH_PCC_HALT_BIT 2
`define SSH_PCC_STOP_BIT 3
`define SSH_PCC_RST 4'h0
`define SSH_CFG_RST 8'h00
`define SSH_TEST_EN_LSB 2

// ==========================================================================
// timing, in main clock periods, and the cycle counts derived from them
`define SSH_MAIN_PERIODS_PER_MCLK 1
`define SSH_STOP_WAIT_PERIODS 512
`define SSH_RESET_WAIT_PERIODS 56
`define SSH_STOP_WAIT_CYC (`SSH_STOP_WAIT_PERIODS * `SSH_MAIN_PERIODS_PER_MCLK)
`define SSH_RESET_WAIT_CYC (`SSH_RESET_WAIT_PERIODS * `SSH_MAIN_PERIODS_PER_MCLK)

`endif

/* rtl/ssh_pkg.sv */
// types shared by the standby controller files
// assumes nothing beyond a SystemVerilog compiler
package ssh_pkg;

	// ======================================================================
	// controller states
	typedef enum logic [2:0] {
		SSH_ST_RUN = 3'b000,
		SSH_ST_HALT = 3'b001,
		SSH_ST_STOP = 3'b010,
		SSH_ST_WAIT = 3'b011,
		SSH_ST_RESET_WAIT = 3'b100
	} ssh_state_t;

	// software configuration, one byte, msb first
	typedef struct packed {
		logic spare;
		logic main_osc_stop;
		logic cpu_on_sub_clock;
		logic ctmr_sub_clock_sel;
		logic tec_event_pin_sel;
		logic sio_ext_clock_sel;
		logic noise_filter_bypass_bit;
		logic master_interrupt_enable;
	} ssh_cfg_t;

	// run enables handed to the peripherals
	typedef struct packed {
		logic interval_timer;
		logic serial_if;
		logic event_counter;
		logic timer_counter;
		logic clock_timer;
		logic ext_irq_zero;
	} ssh_periph_run_t;

endpackage

/* rtl/ssh_wait_counter.sv */
// release and startup wait counter of the standby controller
// assumes a start pulse one cycle before the waiting state begins
`timescale 1ns/1ps

module ssh_wait_counter #(
	parameter int WIDTH = 10,
	parameter logic [9:0] RST_LOAD = 10'h038
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// control
	input wire logic start_in,
	input wire logic [WIDTH-1:0] len_in,
	// result
	output logic done_out
);
	logic [WIDTH-1:0] cnt_reg;

	// ======================================================================
	// counts len cycles after start; reset preloads the startup wait
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= RST_LOAD[WIDTH-1:0];
		end else if (start_in) begin
			cnt_reg <= len_in;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// last counted cycle
	assign done_out = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // ssh_wait_counter

/* rtl/ssh_test_source.sv */
// one testable wake source: sticky request flag gated by its enable flag
// assumes set and clear are synchronous one-cycle pulses
`timescale 1ns/1ps

module ssh_test_source (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// event and software access
	input wire logic set_in,
	input wire logic clr_in,
	input wire logic en_in,
	// state
	output logic flag_out,
	output logic release_out
);
	logic flag_reg;

	// ======================================================================
	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_reg <= 1'b0;
		end else if (set_in) begin
			flag_reg <= 1'b1;
		end else if (clr_in) begin
			flag_reg <= 1'b0;
		end
	end

	assign flag_out = flag_reg;
	assign release_out = flag_reg & en_in;
endmodule // ssh_test_source

/* rtl/ssh_standby_ctrl.sv */
// standby controller: stop and halt entry, peripheral gating, wake-up and release wait
// assumes cpu strobes and interrupt flags synchronous to mclk_in, which stands for
// the main clock and keeps running so the controller can model its restart
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "ssh_standby_map.svh"

module ssh_standby_ctrl
	import ssh_pkg::*;
#(
	parameter int IRQ_N = 6,
	parameter bit STOP_WAIT_EN = 1'b1
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// cpu instruction strobes
	input wire logic stop_exec_in,
	input wire logic halt_exec_in,
	// interrupt request and enable flags, non-testable sources
	input wire logic [IRQ_N-1:0] irq_req_in,
	input wire logic [IRQ_N-1:0] irq_en_in,
	// testable source events
	input wire logic key_edge_test_input_in,
	input wire logic clock_timer_test_input_in,
	// clock gating and peripheral enables
	output logic main_osc_run_out,
	output logic cpu_clk_en_out,
	output ssh_pkg::ssh_periph_run_t periph_run_out,
	// release results
	output logic resume_pulse_out,
	output logic vectored_out,
	output logic reset_fetch_out
);
	import ssh_pkg::*;

	localparam int WAIT_W = 10;
	localparam logic [WAIT_W-1:0] STOP_WAIT_LEN = WAIT_W'(`SSH_STOP_WAIT_CYC);
	localparam logic [WAIT_W-1:0] RESET_WAIT_LEN = WAIT_W'(`SSH_RESET_WAIT_CYC);

	ssh_state_t state_reg;
	ssh_state_t state_next;
	ssh_cfg_t cfg_reg;
	logic [3:0] pcc_reg;
	logic [1:0] test_en_reg;
	logic [1:0] test_flag;
	logic [1:0] test_rel;
	logic [1:0] test_set;
	logic [1:0] test_clr;
	logic irq_wake;
	logic wake_any;
	logic wait_start;
	logic wait_done;
	logic resume_reg;
	logic vectored_reg;
	logic fetch_reg;
	logic [7:0] rdata_reg;
	logic osc_on;

	// ======================================================================
	// decoding shared by gating and assertions
	function automatic logic is_standby(input ssh_state_t st);
		is_standby = (st == SSH_ST_HALT) || (st == SSH_ST_STOP) || (st == SSH_ST_WAIT);
	endfunction

	// ======================================================================
	// testable wake sources
	assign test_set = {clock_timer_test_input_in, key_edge_test_input_in};
	assign test_clr = (reg_wr_in && reg_addr_in == `SSH_ADDR_TEST) ? reg_wdata_in[1:0] : 2'h0;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_test
			ssh_test_source u_src (
				.mclk_in(mclk_in),
				.rst_n_in(rst_n_in),
				.set_in(test_set[i]),
				.clr_in(test_clr[i]),
				.en_in(test_en_reg[i]),
				.flag_out(test_flag[i]),
				.release_out(test_rel[i])
			);
		end
	endgenerate

	// wake when any request has its enable set; masked ones are ignored
	assign irq_wake = |(irq_req_in & irq_en_in);
	assign wake_any = irq_wake | (|test_rel);

	// ======================================================================
	// release and startup wait counter
	ssh_wait_counter #(
		.WIDTH(WAIT_W),
		.RST_LOAD(RESET_WAIT_LEN)
	) u_wait (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(wait_start),
		.len_in(STOP_WAIT_LEN),
		.done_out(wait_done)
	);

	// ======================================================================
	// state machine next state
	always_comb begin
		state_next = state_reg;
		wait_start = 1'b0;
		case (state_reg)
			SSH_ST_RESET_WAIT: begin
				if (wait_done) begin
					state_next = SSH_ST_RUN;
				end
			end
			SSH_ST_RUN: begin
				// stop is refused while the cpu runs on the sub clock
				if (stop_exec_in && !cfg_reg.cpu_on_sub_clock) begin
					if (wake_any) begin
						// pending request: halt-like gating, then the stop wait
						if (STOP_WAIT_EN) begin
							state_next = SSH_ST_WAIT;
							wait_start = 1'b1;
						end else begin
							state_next = SSH_ST_HALT;
						end
					end else begin
						state_next = SSH_ST_STOP;
					end
				end else if (halt_exec_in) begin
					state_next = SSH_ST_HALT;
				end
			end
			SSH_ST_HALT: begin
				if (wake_any) begin
					state_next = SSH_ST_RUN;
				end
			end
			SSH_ST_STOP: begin
				if (wake_any) begin
					// build-time choice between the long wait and none
					if (STOP_WAIT_EN) begin
						state_next = SSH_ST_WAIT;
						wait_start = 1'b1;
					end else begin
						state_next = SSH_ST_RUN;
					end
				end
			end
			SSH_ST_WAIT: begin
				// counted on the restarted oscillator before cpu clock reopens
				if (wait_done) begin
					state_next = SSH_ST_RUN;
				end
			end
			default: begin
				state_next = SSH_ST_RUN;
			end
		endcase
	end

	// state register; reset always restarts through the startup wait
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= SSH_ST_RESET_WAIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// ======================================================================
	// processor clock control: hardware standby bits, software clock select
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pcc_reg <= `SSH_PCC_RST;
		end else if (state_reg == SSH_ST_RUN && state_next != SSH_ST_RUN) begin
			pcc_reg[`SSH_PCC_STOP_BIT] <= (state_next != SSH_ST_HALT) || !halt_exec_in;
			pcc_reg[`SSH_PCC_HALT_BIT] <= (state_next == SSH_ST_HALT) && halt_exec_in;
		end else if (is_standby(state_reg) && state_next == SSH_ST_RUN) begin
			pcc_reg[`SSH_PCC_STOP_BIT] <= 1'b0;
			pcc_reg[`SSH_PCC_HALT_BIT] <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == `SSH_ADDR_PCC) begin
			pcc_reg[1:0] <= reg_wdata_in[1:0];
		end
	end

	// ======================================================================
	// configuration and test enables; nothing here moves during standby
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_reg <= `SSH_CFG_RST;
			test_en_reg <= 2'h0;
		end else if (reg_wr_in && !is_standby(state_reg)) begin
			if (reg_addr_in == `SSH_ADDR_CFG) begin
				cfg_reg <= reg_wdata_in;
			end
			if (reg_addr_in == `SSH_ADDR_TEST) begin
				test_en_reg <= reg_wdata_in[`SSH_TEST_EN_LSB +: 2];
			end
		end
	end

	// ======================================================================
	// release outcome: inline resume or vectored interrupt
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			resume_reg <= 1'b0;
			vectored_reg <= 1'b0;
		end else begin
			resume_reg <= is_standby(state_reg) && state_next == SSH_ST_RUN;
			if (is_standby(state_reg) && state_next == SSH_ST_RUN) begin
				// testable sources alone never vector; request flags left set
				vectored_reg <= cfg_reg.master_interrupt_enable && irq_wake;
			end else if (state_reg == SSH_ST_RUN && state_next != SSH_ST_RUN) begin
				vectored_reg <= 1'b0;
			end
		end
	end

	// reset vector fetch strobe at the end of the startup wait
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fetch_reg <= 1'b0;
		end else begin
			fetch_reg <= (state_reg == SSH_ST_RESET_WAIT) && wait_done;
		end
	end

	// ======================================================================
	// clock gating and peripheral enables
	assign osc_on = (state_reg != SSH_ST_STOP) && !cfg_reg.main_osc_stop;
	assign main_osc_run_out = osc_on;
	assign cpu_clk_en_out = (state_reg == SSH_ST_RUN);
	assign periph_run_out.interval_timer = osc_on;
	assign periph_run_out.serial_if = cfg_reg.sio_ext_clock_sel || osc_on;
	assign periph_run_out.event_counter = cfg_reg.tec_event_pin_sel || osc_on;
	assign periph_run_out.timer_counter = osc_on;
	assign periph_run_out.clock_timer = (state_reg != SSH_ST_STOP)
		|| cfg_reg.ctmr_sub_clock_sel;
	// irq zero detection needs the filter bypassed while standing by
	assign periph_run_out.ext_irq_zero = !is_standby(state_reg)
		|| cfg_reg.noise_filter_bypass_bit;
	assign resume_pulse_out = resume_reg;
	assign vectored_out = vectored_reg;
	assign reset_fetch_out = fetch_reg;

	// ======================================================================
	// register read, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`SSH_ADDR_PCC: rdata_reg <= {4'h0, pcc_reg};
				`SSH_ADDR_CFG: rdata_reg <= cfg_reg;
				`SSH_ADDR_TEST: rdata_reg <= {4'h0, test_en_reg, test_flag};
				`SSH_ADDR_STAT: rdata_reg <= {3'h0, vectored_reg, osc_on, state_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata_out = rdata_reg;

	// ======================================================================
	// assertions and helper logic
	logic [WAIT_W:0] run_len;
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_len <= (WAIT_W+1)'(1);
		end else if (state_next != state_reg) begin
			run_len <= (WAIT_W+1)'(1);
		end else if (run_len != '1) begin
			run_len <= run_len + 1'b1;
		end
	end

	a_stop_sets_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_RUN && stop_exec_in && !cfg_reg.cpu_on_sub_clock
		|=> pcc_reg[`SSH_PCC_STOP_BIT] && !cpu_clk_en_out)
		else $error("stop did not set its control bit");
	a_halt_sets_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_RUN && halt_exec_in && !stop_exec_in
		|=> pcc_reg[`SSH_PCC_HALT_BIT] && state_reg == SSH_ST_HALT)
		else $error("halt did not set its control bit");
	a_stop_main_only: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_RUN && stop_exec_in && !halt_exec_in && cfg_reg.cpu_on_sub_clock
		|=> state_reg == SSH_ST_RUN)
		else $error("stop entered on sub clock");
	a_stop_gating: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_STOP |-> !main_osc_run_out && !periph_run_out.interval_timer
		&& !periph_run_out.timer_counter)
		else $error("oscillator or timers run in stop");
	a_masked_no_wake: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_HALT && !wake_any |=> state_reg == SSH_ST_HALT)
		else $error("halt left without enabled request");
	a_halt_wakes: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_HALT && wake_any |=> state_reg == SSH_ST_RUN && resume_pulse_out)
		else $error("halt not released by enabled request");
	a_pending_stop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_RUN && stop_exec_in && !cfg_reg.cpu_on_sub_clock && wake_any
		|=> main_osc_run_out || cfg_reg.main_osc_stop)
		else $error("pending stop stopped the oscillator");
	a_stop_wait_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_WAIT && state_next == SSH_ST_RUN
		|-> run_len == (WAIT_W+1)'(`SSH_STOP_WAIT_CYC))
		else $error("stop release wait has wrong length");
	a_reset_wait_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_RESET_WAIT && state_next == SSH_ST_RUN
		|-> run_len == (WAIT_W+1)'(`SSH_RESET_WAIT_CYC) ##1 reset_fetch_out)
		else $error("startup wait has wrong length");
	a_test_no_vector: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_standby(state_reg) && state_next == SSH_ST_RUN && !irq_wake
		|=> !vectored_out)
		else $error("testable wake produced a vector");

	c_stop_release: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_STOP ##1 state_reg == SSH_ST_WAIT);
	c_halt_vector: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_HALT ##1 vectored_out);
	c_test_wake: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == SSH_ST_HALT && !irq_wake && |test_rel);
endmodule // ssh_standby_ctrl

/* verification/ssh_standby_ctrl_tb.sv */
// self-checking bench for the standby controller: entry, gating, wake and waits
// assumes the design files under rtl/ and the map header on the include path
`timescale 1ns/1ps
`include "ssh_standby_map.svh"

module ssh_standby_ctrl_tb;
	import ssh_pkg::*;

	// ======================================================================
	// signals
	logic mclk_in, rst_n_in, reg_wr_in, reg_rd_in, stop_exec_in, halt_exec_in;
	logic [1:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, rd;
	logic [5:0] irq_req_in, irq_en_in;
	logic key_edge_test_input_in, clock_timer_test_input_in;
	logic main_osc_run_out, cpu_clk_en_out, resume_pulse_out, vectored_out, reset_fetch_out;
	ssh_periph_run_t periph_run_out;
	int err_total = 0;
	int compares = 0;

	ssh_standby_ctrl #(.IRQ_N(6), .STOP_WAIT_EN(1'b1)) i_ssh_standby_ctrl (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.stop_exec_in(stop_exec_in), .halt_exec_in(halt_exec_in),
		.irq_req_in(irq_req_in), .irq_en_in(irq_en_in),
		.key_edge_test_input_in(key_edge_test_input_in),
		.clock_timer_test_input_in(clock_timer_test_input_in),
		.main_osc_run_out(main_osc_run_out), .cpu_clk_en_out(cpu_clk_en_out),
		.periph_run_out(periph_run_out), .resume_pulse_out(resume_pulse_out),
		.vectored_out(vectored_out), .reset_fetch_out(reset_fetch_out));

	// ======================================================================
	// clock, 40 ns period
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	// ======================================================================
	// compare and closing tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp, input string msg);
		compares++;
		if (got != exp) begin
			err_total++;
			$display("unexpected at %0t: %s took %0d cycles, exp %0d", $time, msg, got, exp);
		end
	endtask

	task automatic end_sim;
		if (err_total == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ======================================================================
	// bus and cpu drivers, all changes by nba right after a rising edge
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [1:0] a);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 rd = reg_rdata_out;
	endtask

	// one-cycle instruction strobe; the idle cycle after it stands for the no-op
	task automatic cmd(input bit stp);
		@(posedge mclk_in);
		if (stp) stop_exec_in <= 1'b1;
		else halt_exec_in <= 1'b1;
		@(posedge mclk_in);
		stop_exec_in <= 1'b0;
		halt_exec_in <= 1'b0;
		#1;
	endtask

	// counts edges until the cpu clock reopens; exp 0 skips the count check
	task automatic wait_run(input int exp);
		int n;
		n = 0;
		while (cpu_clk_en_out !== 1'b1 && n < 2000) begin
			@(posedge mclk_in);
			#1 n++;
		end
		if (exp != 0) chk_cnt(n, exp, "release latency");
	endtask

	task automatic resume_chk(input logic vec);
		chk({7'h00, vectored_out}, {7'h00, vec}, "vectored");
		chk({7'h00, resume_pulse_out}, 8'h01, "resume pulse");
		@(posedge mclk_in);
		// software clears the request flags before the next standby
		irq_req_in <= 6'h00;
		#1 chk({7'h00, resume_pulse_out}, 8'h00, "resume pulse length");
	endtask

	task automatic do_reset;
		int n;
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		n = 0;
		while (reset_fetch_out !== 1'b1 && n < 200) begin
			@(posedge mclk_in);
			#1 n++;
		end
		chk_cnt(n, `SSH_RESET_WAIT_CYC, "startup wait");
		chk({7'h00, cpu_clk_en_out}, 8'h01, "cpu clock after reset");
	endtask

	// ======================================================================
	// scenarios
	// halt, masked request ignored, enabled request wakes and vectors
	task automatic t_halt_irq;
		reg_wr(`SSH_ADDR_CFG, 8'h01);
		irq_en_in <= 6'h04;
		cmd(1'b0);
		chk({7'h00, cpu_clk_en_out}, 8'h00, "halt cpu clock");
		chk({7'h00, main_osc_run_out}, 8'h01, "halt oscillator");
		chk({2'b00, periph_run_out}, 8'h3E, "halt peripherals");
		reg_rd(`SSH_ADDR_PCC);
		chk(rd & 8'h0F, 8'h04, "pcc in halt");
		@(posedge mclk_in);
		irq_req_in <= 6'h08;
		repeat (5) @(posedge mclk_in);
		#1 chk({7'h00, cpu_clk_en_out}, 8'h00, "masked request woke");
		@(posedge mclk_in);
		irq_req_in <= 6'h0C;
		wait_run(1);
		resume_chk(1'b1);
		reg_rd(`SSH_ADDR_PCC);
		chk(rd & 8'h0F, 8'h00, "pcc after release");
	endtask

	// halt on sub clock with master enable off; stop on sub clock refused
	task automatic t_sub_clock;
		reg_wr(`SSH_ADDR_PCC, 8'h03);
		reg_rd(`SSH_ADDR_PCC);
		chk(rd & 8'h0F, 8'h03, "clock select written");
		// let the clock switch settle before any standby command
		repeat (4) @(posedge mclk_in);
		reg_wr(`SSH_ADDR_CFG, 8'h20);
		irq_en_in <= 6'h01;
		cmd(1'b0);
		chk({7'h00, cpu_clk_en_out}, 8'h00, "halt on sub clock");
		@(posedge mclk_in);
		irq_req_in <= 6'h01;
		wait_run(1);
		resume_chk(1'b0);
		cmd(1'b1);
		chk({7'h00, cpu_clk_en_out}, 8'h01, "stop on sub clock");
		reg_rd(`SSH_ADDR_STAT);
		chk(rd & 8'h07, 8'h00, "state after refused stop");
		reg_wr(`SSH_ADDR_PCC, 8'h00);
	endtask

	// stop with two peripheral selections, wake after the long wait
	task automatic t_stop;
		logic [7:0] cfg [2] = '{8'h15, 8'h0A};
		logic [7:0] per [2] = '{8'h12, 8'h09};
		for (int i = 0; i < 2; i++) begin
			reg_wr(`SSH_ADDR_CFG, cfg[i]);
			irq_en_in <= 6'h20;
			cmd(1'b1);
			chk({7'h00, main_osc_run_out}, 8'h00, "stop oscillator");
			chk({2'b00, periph_run_out}, per[i], "stop peripherals");
			reg_rd(`SSH_ADDR_PCC);
			chk(rd & 8'h0F, 8'h08, "pcc in stop");
			reg_rd(`SSH_ADDR_STAT);
			chk(rd & 8'h07, 8'h02, "stop state");
			@(posedge mclk_in);
			irq_req_in <= 6'h20;
			wait_run(`SSH_STOP_WAIT_CYC + 1);
			chk({7'h00, main_osc_run_out}, 8'h01, "oscillator restarted");
			resume_chk(cfg[i][0]);
			reg_rd(`SSH_ADDR_CFG);
			chk(rd, cfg[i], "cfg retained");
		end
	endtask

	// commands given with an enabled request already pending
	task automatic t_pending;
		reg_wr(`SSH_ADDR_CFG, 8'h01);
		irq_en_in <= 6'h02;
		irq_req_in <= 6'h02;
		cmd(1'b1);
		chk({7'h00, main_osc_run_out}, 8'h01, "pending stop keeps oscillator");
		chk({7'h00, cpu_clk_en_out}, 8'h00, "pending stop gates cpu");
		wait_run(`SSH_STOP_WAIT_CYC);
		cmd(1'b0);
		wait_run(1);
		resume_chk(1'b1);
	endtask

	// both testable sources wake without vectoring and keep their flags
	task automatic t_test_src;
		logic [7:0] en;
		reg_wr(`SSH_ADDR_CFG, 8'h01);
		irq_en_in <= 6'h00;
		for (int i = 0; i < 2; i++) begin
			en = 8'h04 << i;
			reg_wr(`SSH_ADDR_TEST, en);
			cmd(1'b0);
			@(posedge mclk_in);
			if (i == 0) key_edge_test_input_in <= 1'b1;
			else clock_timer_test_input_in <= 1'b1;
			@(posedge mclk_in);
			key_edge_test_input_in <= 1'b0;
			clock_timer_test_input_in <= 1'b0;
			wait_run(0);
			chk({7'h00, cpu_clk_en_out}, 8'h01, "test source wake");
			resume_chk(1'b0);
			reg_rd(`SSH_ADDR_TEST);
			chk(rd & 8'h0F, en | (8'h01 << i), "test flag held");
			reg_wr(`SSH_ADDR_TEST, en | (8'h01 << i));
			reg_rd(`SSH_ADDR_TEST);
			chk(rd & 8'h0F, en, "test flag cleared");
			reg_wr(`SSH_ADDR_TEST, 8'h00);
		end
	endtask

	// reset during halt runs the normal startup and clears configuration
	task automatic t_reset_halt;
		irq_en_in <= 6'h00;
		cmd(1'b0);
		chk({7'h00, cpu_clk_en_out}, 8'h00, "halt before reset");
		do_reset();
		reg_rd(`SSH_ADDR_CFG);
		chk(rd, 8'h00, "cfg after reset");
	endtask

	// ======================================================================
	// main sequence and watchdog
	initial begin
		rst_n_in = 1'b0;
		reg_addr_in = 2'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		stop_exec_in = 1'b0;
		halt_exec_in = 1'b0;
		irq_req_in = 6'h00;
		irq_en_in = 6'h00;
		key_edge_test_input_in = 1'b0;
		clock_timer_test_input_in = 1'b0;
		do_reset();
		t_halt_irq();
		t_sub_clock();
		t_stop();
		t_pending();
		t_test_src();
		t_reset_halt();
		end_sim();
	end

	// the run needs about 1800 cycles; allow about eleven times that
	initial begin
		#(40 * 20000);
		err_total++;
		end_sim();
	end

endmodule // ssh_standby_ctrl_tb
